/* design/smf_framer.sv */
// Serial message framer: four framing modes, mailbox, transmit buffer.
`timescale 1ns/100ps
module smf_framer (
    // Clock and reset.
    input wire logic mclk,
    input wire logic arst_n,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Received bytes from the line receiver.
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    // Bytes to the line transmitter.
    output logic [7:0] tx_byte_q,
    output logic tx_valid_q,
    input wire logic tx_ready
);
    import smf_pkg::*;
    // ==========================================================
    // Configuration and status registers.
    logic [2:0] ctrl_q;                // Static mode and flow enable.
    logic [7:0] end_q;                 // End character.
    logic [5:0] fixlen_q;              // Fixed receive length.
    logic [15:0] timeout_q;            // Gap limit in ticks.
    logic [5:0] tx_len_q;              // Bytes to send.
    logic [MBX_AW-1:0] tx_wr_idx_q;    // Next transmit buffer slot.
    logic [5:0] mbx_cnt_q;             // Mailbox count word.
    logic ready_q;                     // A message waits in the mailbox.
    logic discard_q;                   // A partial message was dropped.
    logic paused_q;                    // Partner asked us to pause.
    logic [15:0] lines_q;              // Printer line counter.
    logic [6:0] col_q;                 // Printer column.
    logic [31:0] rdata_reg_q;          // Register read result.
    logic rd_mem_q;                    // Last read went to the mailbox.
    logic [7:0] mbx_rdata;             // Mailbox read data.
    logic [7:0] txb_rdata;             // Transmit buffer read data.
    smf_tx_state_t tx_st_q;            // Transmit engine state.
    // Busy is needed by the status read mux, so it is declared before the decode.
    wire tx_busy = tx_st_q != TX_IDLE;
    wire [1:0] mode = ctrl_q[1:0];
    wire flow_en = ctrl_q[CTRL_FLOW_BIT];
    // ==========================================================
    // Address decode.
    wire wr_ctrl = reg_wr && reg_addr == REG_CTRL;
    wire wr_end = reg_wr && reg_addr == REG_END;
    wire wr_fix = reg_wr && reg_addr == REG_FIXLEN;
    wire wr_tmo = reg_wr && reg_addr == REG_TIMEOUT;
    wire wr_txlen = reg_wr && reg_addr == REG_TXLEN;
    wire wr_txdata = reg_wr && reg_addr == REG_TXDATA;
    wire wr_status = reg_wr && reg_addr == REG_STATUS;
    wire rd_mem = reg_rd && reg_addr[7] && reg_addr[1:0] == 2'h0;
    wire [MBX_AW-1:0] mbx_raddr = reg_addr[MBX_AW+1:2];
    // Unmapped addresses read as zero.
    wire [31:0] reg_val =
        reg_addr == REG_CTRL ? {29'h0, ctrl_q} :
        reg_addr == REG_END ? {24'h0, end_q} :
        reg_addr == REG_FIXLEN ? {26'h0, fixlen_q} :
        reg_addr == REG_TIMEOUT ? {16'h0, timeout_q} :
        reg_addr == REG_TXLEN ? {26'h0, tx_len_q} :
        reg_addr == REG_STATUS ? {28'h0, paused_q, tx_busy, discard_q, ready_q} :
        reg_addr == REG_MBXCNT ? {26'h0, mbx_cnt_q} :
        reg_addr == REG_LINES ? {16'h0, lines_q} : 32'h0;
    // Both sources are flops; the select is registered with them.
    assign reg_rdata = rd_mem_q ? {24'h0, mbx_rdata} : rdata_reg_q;
    // ==========================================================
    // Tick divider for the gap timer.
    logic [4:0] div_q;
    wire tick = div_q == 5'(TICK_CYC - 1);
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= 5'h0;
        end else begin
            div_q <= tick ? 5'h0 : div_q + 5'h1;
        end
    end
    // ==========================================================
    // Receive path.
    logic rx_active_q;                 // A message is in progress.
    logic [5:0] rx_idx_q;              // Bytes stored so far.
    logic [15:0] gap_q;                // Ticks since the last data character.
    wire is_flow = flow_en && (rx_byte == FLOW_RESUME || rx_byte == FLOW_PAUSE);
    wire rx_data = rx_valid && !is_flow && mode != MODE_PRN;
    wire rx_we = rx_data && rx_idx_q < 6'(MBX_DEPTH);
    wire expire = rx_active_q && !rx_data && tick && gap_q >= timeout_q;
    wire overflow = rx_data && rx_idx_q == 6'(MBX_DEPTH);
    wire [5:0] rx_next = rx_idx_q + 6'h1;
    // A message completes on gap expiry, end character or fixed length.
    wire done_gap = expire && mode == MODE_GAP;
    wire done_end = rx_we && mode == MODE_END && rx_byte == end_q;
    wire done_fix = rx_we && mode == MODE_FIX && rx_next == fixlen_q;
    wire rx_done = done_gap || done_end || done_fix;
    wire rx_drop = (expire && mode != MODE_GAP) || overflow;
    wire [5:0] done_cnt = done_gap ? rx_idx_q : rx_next;
    // Track message progress and the gap since the last data character.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rx_active_q <= 1'b0;
            rx_idx_q <= 6'h0;
            gap_q <= 16'h0;
        end else if (rx_done || rx_drop) begin
            rx_active_q <= 1'b0;
            rx_idx_q <= 6'h0;
            gap_q <= 16'h0;
        end else if (rx_we) begin
            rx_active_q <= 1'b1;
            rx_idx_q <= rx_next;
            gap_q <= 16'h0;
        end else if (rx_active_q && tick) begin
            gap_q <= gap_q + 16'h1;
        end
    end
    // The count word moves only when a message completes.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mbx_cnt_q <= 6'h0;
        end else if (rx_done) begin
            mbx_cnt_q <= done_cnt;
        end
    end
    // Sticky flags: a new event wins over a software clear.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ready_q <= 1'b0;
            discard_q <= 1'b0;
        end else begin
            ready_q <= rx_done || (ready_q && !(wr_status && reg_wdata[ST_READY_BIT]));
            discard_q <= rx_drop || (discard_q && !(wr_status && reg_wdata[ST_DISCARD_BIT]));
        end
    end
    // Flow characters steer the transmitter, never the mailbox.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            paused_q <= 1'b0;
        end else if (!flow_en) begin
            paused_q <= 1'b0;
        end else if (rx_valid && is_flow) begin
            paused_q <= rx_byte == FLOW_PAUSE;
        end
    end
    smf_mem u_mbx (
        .mclk(mclk),
        .we(rx_we),
        .waddr(rx_idx_q[MBX_AW-1:0]),
        .wdata(rx_byte),
        .raddr(mbx_raddr),
        .rdata_q(mbx_rdata)
    );
    // ==========================================================
    // Configuration registers; mode is meant to stay static while busy.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= CTRL_RESET;
            end_q <= END_RESET;
            fixlen_q <= FIXLEN_RESET;
            timeout_q <= TIMEOUT_RESET;
        end else begin
            if (wr_ctrl) ctrl_q <= reg_wdata[2:0];
            if (wr_end) end_q <= reg_wdata[7:0];
            if (wr_fix) fixlen_q <= reg_wdata[5:0];
            if (wr_tmo) timeout_q <= reg_wdata[15:0];
        end
    end
    // Read data stand in the cycle after the strobe.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg_q <= 32'h0;
            rd_mem_q <= 1'b0;
        end else begin
            rdata_reg_q <= reg_rd ? reg_val : 32'h0;
            rd_mem_q <= rd_mem;
        end
    end
    // ==========================================================
    // Transmit path.
    logic [5:0] tx_idx_q;              // Byte being sent.
    logic last_q;                      // Data byte just sent ended the message.
    wire start = wr_txlen && !tx_busy && reg_wdata[5:0] != 6'h0;
    wire tx_hs = tx_valid_q && tx_ready;
    wire is_end = (mode == MODE_END || mode == MODE_PRN) && tx_byte_q == end_q;
    wire is_last = is_end || tx_idx_q + 6'h1 == tx_len_q;
    wire need_break = mode == MODE_PRN && tx_byte_q != CHAR_LF && col_q == LINE_WIDTH - 7'h1 && !is_end;
    // Buffer fill pointer restarts with each send.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tx_wr_idx_q <= '0;
            tx_len_q <= 6'h0;
        end else if (start) begin
            tx_wr_idx_q <= '0;
            tx_len_q <= reg_wdata[5:0];
        end else if (wr_txdata && !tx_busy) begin
            tx_wr_idx_q <= tx_wr_idx_q + 1'b1;
        end
    end
    smf_mem u_txb (
        .mclk(mclk),
        .we(wr_txdata && !tx_busy),
        .waddr(tx_wr_idx_q),
        .wdata(reg_wdata[7:0]),
        .raddr(tx_idx_q[MBX_AW-1:0]),
        .rdata_q(txb_rdata)
    );
    // Fetch, present, and in printer mode break long lines.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tx_st_q <= TX_IDLE;
            tx_idx_q <= 6'h0;
            tx_byte_q <= 8'h0;
            tx_valid_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            case (tx_st_q)
                TX_IDLE: begin
                    if (start) begin
                        tx_idx_q <= 6'h0;
                        tx_st_q <= TX_FETCH;
                    end
                end
                TX_FETCH: begin
                    // A paused partner holds the next byte back.
                    if (!paused_q) tx_st_q <= TX_LOAD;
                end
                TX_LOAD: begin
                    tx_byte_q <= txb_rdata;
                    tx_valid_q <= 1'b1;
                    tx_st_q <= TX_SEND;
                end
                TX_SEND: begin
                    if (tx_hs) begin
                        tx_valid_q <= 1'b0;
                        last_q <= is_last;
                        tx_idx_q <= tx_idx_q + 6'h1;
                        if (need_break) begin
                            tx_byte_q <= CHAR_LF;
                            tx_valid_q <= 1'b1;
                            tx_st_q <= TX_BREAK;
                        end else begin
                            tx_st_q <= is_last ? TX_IDLE : TX_FETCH;
                        end
                    end
                end
                TX_BREAK: begin
                    if (tx_hs) begin
                        tx_valid_q <= 1'b0;
                        tx_st_q <= last_q ? TX_IDLE : TX_FETCH;
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end
    // Printer line state survives between messages.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lines_q <= 16'h0;
            col_q <= 7'h0;
        end else if (tx_hs && mode == MODE_PRN) begin
            if (tx_byte_q == CHAR_LF) begin
                lines_q <= lines_q + 16'h1;
                col_q <= 7'h0;
            end else begin
                col_q <= col_q + 7'h1;
            end
        end
    end
    // ==========================================================
    // Assertions and covers.
    property p_flow_no_store;
        @(posedge mclk) disable iff (!arst_n) rx_valid && is_flow |-> !rx_we;
    endproperty
    a_flow_no_store: assert property (p_flow_no_store) else $error("flow char stored");
    property p_prn_drop;
        @(posedge mclk) disable iff (!arst_n) rx_valid && mode == MODE_PRN |-> !rx_we && !rx_done;
    endproperty
    a_prn_drop: assert property (p_prn_drop) else $error("printer mode stored a byte");
    property p_fix_count;
        @(posedge mclk) disable iff (!arst_n) rx_done && mode == MODE_FIX |=> mbx_cnt_q == fixlen_q && ready_q;
    endproperty
    a_fix_count: assert property (p_fix_count) else $error("fixed count wrong");
    property p_end_count;
        @(posedge mclk) disable iff (!arst_n)
            rx_done && mode == MODE_END |-> rx_byte == end_q ##1 mbx_cnt_q == $past(rx_idx_q) + 6'h1;
    endproperty
    a_end_count: assert property (p_end_count) else $error("end count wrong");
    property p_drop_keeps;
        @(posedge mclk) disable iff (!arst_n) rx_drop |=> $stable(mbx_cnt_q) && discard_q && !rx_active_q;
    endproperty
    a_drop_keeps: assert property (p_drop_keeps) else $error("discard touched count");
    property p_gap_done;
        @(posedge mclk) disable iff (!arst_n) expire && mode == MODE_GAP |=> ready_q && mbx_cnt_q == $past(rx_idx_q);
    endproperty
    a_gap_done: assert property (p_gap_done) else $error("gap end missed");
    property p_tx_end_stop;
        @(posedge mclk) disable iff (!arst_n) tx_hs && tx_st_q == TX_SEND && is_end |=> !tx_busy && !tx_valid_q;
    endproperty
    a_tx_end_stop: assert property (p_tx_end_stop) else $error("send ran past end char");
    property p_tx_len;
        @(posedge mclk) disable iff (!arst_n) tx_st_q == TX_SEND |-> tx_idx_q < tx_len_q;
    endproperty
    a_tx_len: assert property (p_tx_len) else $error("send ran past length");
    property p_lines_kept;
        @(posedge mclk) disable iff (!arst_n) start |=> $stable(lines_q) && $stable(col_q);
    endproperty
    a_lines_kept: assert property (p_lines_kept) else $error("line state lost");
    property p_flow_gap;
        @(posedge mclk) disable iff (!arst_n) rx_valid && is_flow && rx_active_q && !tick |=> $stable(gap_q);
    endproperty
    a_flow_gap: assert property (p_flow_gap) else $error("flow char moved gap timer");
    c_end_msg: cover property (@(posedge mclk) disable iff (!arst_n) done_end);
    c_drop: cover property (@(posedge mclk) disable iff (!arst_n) rx_drop && mode == MODE_FIX);
    c_break: cover property (@(posedge mclk) disable iff (!arst_n) tx_st_q == TX_BREAK && tx_hs);
endmodule : smf_framer

/* design/smf_mem.sv */
// Byte memory with one write port and one registered read port.
`timescale 1ns/100ps
module smf_mem (
    // Clock.
    input wire logic mclk,
    // Write port.
    input wire logic we,
    input wire logic [smf_pkg::MBX_AW-1:0] waddr,
    input wire logic [7:0] wdata,
    // Read port.
    input wire logic [smf_pkg::MBX_AW-1:0] raddr,
    output logic [7:0] rdata_q
);
    import smf_pkg::*;
    // ==========================================================
    // Storage has no reset; software only trusts bytes below the count word.
    logic [7:0] mem [MBX_DEPTH];
    // Write and registered read share one short process.
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_q <= mem[raddr];
    end
endmodule : smf_mem

/* design/smf_pkg.sv */
// Constants, register map and field layout of the serial message framer.
package smf_pkg;
    // ==========================================================
    // Register offsets (byte addresses on the 8-bit register port).
    localparam logic [7:0] REG_CTRL = 8'h00;    // Mode [1:0], flow control enable [2].
    localparam logic [7:0] REG_END = 8'h04;     // End character.
    localparam logic [7:0] REG_FIXLEN = 8'h08;  // Fixed receive length.
    localparam logic [7:0] REG_TIMEOUT = 8'h0c; // Inter-character timeout in microseconds.
    localparam logic [7:0] REG_TXLEN = 8'h10;   // Writing while idle starts a send of this many bytes, or up to the end character in end and printer modes.
    localparam logic [7:0] REG_TXDATA = 8'h14;  // Appends one byte to the transmit buffer.
    localparam logic [7:0] REG_STATUS = 8'h18;  // Status flags, write one to clear bits 1:0.
    localparam logic [7:0] REG_MBXCNT = 8'h1c;  // Mailbox count word: received byte count.
    localparam logic [7:0] REG_LINES = 8'h20;   // Printer line counter.
    localparam logic [7:0] MBX_BASE = 8'h80;    // Mailbox payload bytes, one per word.
    // ==========================================================
    // Field positions and reset values.
    localparam int CTRL_FLOW_BIT = 2;
    localparam int ST_READY_BIT = 0;
    localparam int ST_DISCARD_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    localparam int ST_PAUSED_BIT = 3;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [7:0] END_RESET = 8'h0d;
    localparam logic [5:0] FIXLEN_RESET = 6'h01;
    localparam logic [15:0] TIMEOUT_RESET = 16'h03e8;
    // ==========================================================
    // Framing modes.
    localparam logic [1:0] MODE_GAP = 2'h0;
    localparam logic [1:0] MODE_END = 2'h1;
    localparam logic [1:0] MODE_FIX = 2'h2;
    localparam logic [1:0] MODE_PRN = 2'h3;
    // ==========================================================
    // Characters and sizes.
    localparam logic [7:0] FLOW_RESUME = 8'h11;
    localparam logic [7:0] FLOW_PAUSE = 8'h13;
    localparam logic [7:0] CHAR_LF = 8'h0a;
    localparam logic [6:0] LINE_WIDTH = 7'h50;
    localparam int MBX_AW = 5;
    localparam int MBX_DEPTH = 32;
    // ==========================================================
    // Timing: the gap timer advances on a one-microsecond tick.
    localparam int CLK_NS = 50;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
    // Transmit engine states.
    typedef enum logic [2:0] {TX_IDLE, TX_FETCH, TX_LOAD, TX_SEND, TX_BREAK} smf_tx_state_t;
endpackage : smf_pkg

/* tb/smf_framer_tb.sv */
// Self-checking bench of the serial message framer.
`timescale 1ns/100ps
module smf_framer_tb;
    import smf_pkg::*;
    // ==========
    // Wiring and bench state.
    logic mclk, arst_n, reg_wr, reg_rd, tx_valid_q, tx_ready, rx_valid, slow;
    logic [7:0] reg_addr, tx_byte_q, rx_byte, r;
    logic [31:0] reg_wdata, reg_rdata, v, old;
    logic [15:0] lf; // Random source state.
    int err_count, check_count, cyc, col, lines;
    logic [7:0] sent [$]; // Bytes handed to the receiver.
    logic [7:0] exp_q [$]; // Bytes expected on the transmit line.
    localparam int TMO = 80; // Gap timeout of 4 us in clock cycles.
    localparam logic [7:0] RA [8] = '{REG_CTRL, REG_END, REG_FIXLEN, REG_TIMEOUT, REG_STATUS, REG_MBXCNT, REG_LINES, 8'h7c};
    localparam logic [31:0] RV [8] = '{32'h0, 32'h0d, 32'h1, 32'h3e8, 32'h0, 32'h0, 32'h0, 32'h0};
    smf_framer u_dut (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .tx_byte_q(tx_byte_q), .tx_valid_q(tx_valid_q), .tx_ready(tx_ready));
    smf_partner u_p (.mclk(mclk), .arst_n(arst_n), .slow(slow), .tx_byte_q(tx_byte_q),
        .tx_valid_q(tx_valid_q), .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // ==========
    // Helpers: bus cycles, random bytes, comparison, verdict.
    function automatic logic [31:0] rx_status(input logic ok);
        return {30'h0, ~ok, ok};
    endfunction : rx_status
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata; // Read data stand only in this cycle.
    endtask : rd
    // One step of the bench's random source.
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    // Framing and flow codes are skipped so payload stays plain.
    task automatic pick(output logic [7:0] b);
        do begin
            lf = lfsr_next(lf);
            b = lf[7:0];
        end while (b inside {END_RESET, CHAR_LF, FLOW_RESUME, FLOW_PAUSE});
    endtask : pick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    // ==========
    // One received message; a failed one must leave the count word alone.
    task automatic rx_case(input logic [2:0] ctrl, input int n, input logic [7:0] last, input int gap, input logic ok);
        logic [7:0] b;
        wr(REG_CTRL, {29'h0, ctrl});
        wr(REG_STATUS, 32'h3);
        rd(REG_MBXCNT, old);
        sent.delete();
        for (int i = 0; i < n; i++) begin
            pick(b);
            sent.push_back(i == n - 1 ? last : b);
            repeat (gap) @(posedge mclk);
            u_p.send_char(sent[i]);
        end
        repeat (TMO + 60) @(posedge mclk);
        rd(REG_MBXCNT, v);
        chk(v, ok ? 32'(n) : old);
        rd(REG_STATUS, v);
        chk(v & 32'h3, ctrl[1:0] == MODE_PRN ? 32'h0 : rx_status(ok));
        for (int i = 0; i < n && ok; i++) begin
            rd(MBX_BASE + 8'(4 * i), v);
            chk(v, {24'h0, sent[i]});
        end
    endtask : rx_case
    // ==========
    // One send; the expected line image includes printer line breaks.
    task automatic tx_msg(input logic [2:0] ctrl, input int len, input int end_at, input logic hold);
        logic [7:0] b;
        logic stop;
        stop = 1'b0;
        wr(REG_CTRL, {29'h0, ctrl});
        for (int i = 0; i < len; i++) begin
            pick(b);
            if (i == end_at) b = END_RESET;
            wr(REG_TXDATA, {24'h0, b});
            if (!stop) begin
                exp_q.push_back(b);
                if (ctrl[1:0] == MODE_PRN) col++;
                if (col == 80) begin
                    exp_q.push_back(CHAR_LF);
                    col = 0;
                    lines++;
                end
            end
            stop |= (b == END_RESET) && (ctrl[1:0] inside {MODE_END, MODE_PRN});
        end
        if (hold) u_p.send_char(FLOW_PAUSE);
        wr(REG_TXLEN, 32'(len));
        if (hold) begin
            repeat (30) @(posedge mclk);
            rd(REG_STATUS, v);
            chk(v[ST_PAUSED_BIT], 1'b1);
            chk(u_p.cnt, exp_q.size() - len);
            u_p.send_char(FLOW_RESUME);
        end
        for (int k = 0; k < 300; k++) begin
            rd(REG_STATUS, v);
            if (v[ST_BUSY_BIT] === 1'b0) break;
        end
        chk(u_p.cnt, exp_q.size());
        foreach (exp_q[i]) chk(u_p.got[i], exp_q[i]);
    endtask : tx_msg
    // Hang guard: runs well past the longest expected sequence.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            tally_and_finish();
        end
    end
    // ==========
    // Main sequence.
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        slow = 1'b0;
        arst_n = 1'b0;
        lf = 16'd4116;
        {err_count, check_count, cyc, col, lines} = '0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(RA[i], v);
            chk(v, RV[i]);
        end
        wr(REG_TIMEOUT, 32'h4);
        pick(r);
        rx_case({1'b0, MODE_GAP}, 3, r, 20, 1'b1);
        rx_case({1'b0, MODE_END}, 5, END_RESET, 20, 1'b1);
        pick(r);
        rx_case({1'b0, MODE_END}, 2, r, 20, 1'b0);
        wr(REG_FIXLEN, 32'h4);
        pick(r);
        rx_case({1'b0, MODE_FIX}, 4, r, 50, 1'b1);
        pick(r);
        rx_case({1'b0, MODE_FIX}, 3, r, 20, 1'b0);
        // A flow code between two bytes must not restart the gap timer.
        for (int g = 25; g <= 60; g += 35) begin
            wr(REG_CTRL, {29'h0, 1'b1, MODE_END});
            wr(REG_STATUS, 32'h3);
            pick(r);
            u_p.send_char(r);
            repeat (g) @(posedge mclk);
            u_p.send_char(FLOW_RESUME);
            repeat (g) @(posedge mclk);
            u_p.send_char(END_RESET);
            repeat (TMO + 60) @(posedge mclk);
            // After the long gap aborts, the lone end character is a message of its own.
            rd(REG_MBXCNT, v);
            chk(v, g == 25 ? 32'h2 : 32'h1);
            rd(REG_STATUS, v);
            chk(v & 32'h3, g == 25 ? 32'h1 : 32'h3);
        end
        pick(r);
        rx_case({1'b1, MODE_PRN}, 2, r, 20, 1'b0);
        slow <= 1'b1;
        tx_msg({1'b0, MODE_GAP}, 6, -1, 1'b0);
        tx_msg({1'b0, MODE_END}, 4, 1, 1'b0);
        tx_msg({1'b0, MODE_FIX}, 5, -1, 1'b0);
        for (int i = 0; i < 4; i++) tx_msg({1'b1, MODE_PRN}, i == 3 ? 8 : 30, i == 3 ? 3 : -1, i == 0);
        rd(REG_LINES, v);
        chk(v, 32'(lines));
        tally_and_finish();
    end
endmodule : smf_framer_tb

/* tb/smf_partner.sv */
// Far-side station model: transmit line sink and receive line source.
`timescale 1ns/100ps
module smf_partner (
    // Clock and reset.
    input wire logic mclk,
    input wire logic arst_n,
    // Stall request from the bench.
    input wire logic slow,
    // Transmit line.
    input wire logic [7:0] tx_byte_q,
    input wire logic tx_valid_q,
    output logic tx_ready,
    // Receive line.
    output logic [7:0] rx_byte,
    output logic rx_valid
);
    logic [7:0] got [0:255]; // Bytes taken off the line, in order.
    int cnt; // Number of bytes taken.
    // ==========
    // Sink: when slow, ready toggles so a byte can wait a cycle.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tx_ready <= 1'b0;
            cnt <= 0;
        end else begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
            if (tx_valid_q && tx_ready) begin
                got[cnt] <= tx_byte_q;
                cnt <= cnt + 1;
            end
        end
    end
    // ==========
    // Source: one-cycle pulse; flow codes go only where the bench asks.
    task automatic send_char(input logic [7:0] b);
        rx_byte <= b;
        rx_valid <= 1'b1;
        @(posedge mclk);
        rx_valid <= 1'b0;
        rx_byte <= ~b; // An idle line never shows a stale byte.
    endtask : send_char
    initial begin
        rx_byte = 8'h00;
        rx_valid = 1'b0;
    end
endmodule : smf_partner
